// File: tcss_pkg.sv
// package of constants and types for the transmit clock and sync pin block
// ======================================================================
// What this block does
// - system clock used only with elastic store or interleaved bus mode
// - compat mode: port one system clock serves all
// - loss indications come from their own detectors
// - indicator source chosen per port by clock control
// - indicators drive pins only in compat mode
// - input sync pulse marks frame or multiframe boundary
// - output sync pulses at frame or multiframe boundary
// - T1 frame pulses double wide on signaling frames
// - line sync timed by line transmit clock, or by receive clock when lineFromRx is set
// - elastic store selects system sync input function
// - system sync sampled on system transmit clock
// - system sync output gives backplane-timed frame pulse
// - serial data sampled on falling edge of chosen clock
package tcss_pkg;
  // ======================================================================
  // sizes
  localparam int NPORT = 8;
  localparam int STAT_W = 16;
  localparam int CFG_W = 6;
  // ======================================================================
  // register offsets
  localparam logic [7:0] ADDR_GLOBAL    = 8'h00;
  localparam logic [7:0] ADDR_INDSEL    = 8'h04;
  localparam logic [7:0] ADDR_PORT0     = 8'h08;
  localparam logic [7:0] ADDR_PORT_STEP = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h28;
  localparam logic [7:0] ADDR_CLEAR     = 8'h2C;
  localparam logic [7:0] ADDR_ENABLE    = 8'h30;
  // global control bits
  localparam int GBL_COMPAT = 0;
  localparam int GBL_IBO    = 1;
  localparam int GBL_SHARED = 2;
  localparam int GBL_W      = 3;
  // indicator select codes, two bits per port
  localparam logic [1:0] IND_ANALOG = 2'h0;
  localparam logic [1:0] IND_FRAMER = 2'h1;
  localparam logic [1:0] IND_FREEZE = 2'h2;
  // ======================================================================
  // framing counts
  localparam logic [8:0] T1_LAST_BIT   = 9'h0C0;
  localparam logic [8:0] E1_LAST_BIT   = 9'h0FF;
  localparam logic [3:0] T1_LAST_FRAME = 4'hB;
  localparam logic [3:0] E1_LAST_FRAME = 4'hF;
  localparam logic [3:0] SIG_FRAME_A   = 4'h5;
  localparam logic [3:0] SIG_FRAME_B   = 4'hB;
  localparam logic [8:0] WIDE_BIT      = 9'h001;
  // backplane frame pulse timing
  localparam int BP_CLOCK_KHZ   = 2048;
  localparam int FRAME_RATE_KHZ = 8;
  localparam int BP_PER_FRAME   = BP_CLOCK_KHZ / FRAME_RATE_KHZ;
  // ======================================================================
  // carriers
  typedef struct packed {
    logic lineFromRx;
    logic t1Mode;
    logic doubleWide;
    logic multiframe;
    logic syncOutput;
    logic esEnable;
  } tcss_port_cfg_type;
  typedef struct packed {
    logic [NPORT-1:0] lineClk;
    logic [NPORT-1:0] rxClk;
    logic [NPORT-1:0] sysClk;
    logic [NPORT-1:0] syncIn;
    logic [NPORT-1:0] serData;
    logic             bpClk;
    logic             sharedSync;
  } tcss_pins_type;
endpackage

// File: tcss_port.sv
// per-port transmit sync engine: frame counting, sync pin in/out and serial capture
`timescale 1ns/1ns
module tcss_port
  import tcss_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // configuration
  input  wire tcss_port_cfg_type cfg,
  input  wire logic              interleaved_bus_mode,
  input  wire logic              compat,
  // sampled pin events
  input  wire logic              lineFall,
  input  wire logic              sysFall,
  input  wire logic              syncLevel,
  input  wire logic              serLevel,
  input  wire logic              bpFrame,
  // outputs
  output logic                   syncOut,
  output logic                   syncOe,
  output logic                   serBit,
  output logic                   serValid,
  output logic                   lineBoundary,
  output logic                   sysBoundary
);
  logic [8:0] bitCnt;
  logic [3:0] frameCnt;
  logic       prevLineSync;
  logic       prevSysSync;

  // ======================================================================
  // decode
  // system clock only with store or interleaved bus mode
  wire useSys = cfg.esEnable | interleaved_bus_mode;
  wire lineInput = ~cfg.esEnable & ~cfg.syncOutput;
  wire sysInput = cfg.esEnable & ~cfg.syncOutput;
  wire esOutput = cfg.esEnable & cfg.syncOutput & ~compat;
  wire [8:0] bitLast = cfg.t1Mode ? T1_LAST_BIT : E1_LAST_BIT;
  wire [3:0] frameLast = cfg.t1Mode ? T1_LAST_FRAME : E1_LAST_FRAME;
  wire bitWrap = bitCnt == bitLast;
  wire frameWrap = frameCnt == frameLast;
  wire restart = lineInput & lineFall & syncLevel & ~prevLineSync;
  wire sysRise = sysInput & sysFall & syncLevel & ~prevSysSync;
  wire [8:0] next_bitCnt = !lineFall ? bitCnt : (restart | bitWrap) ? 9'h000 : 9'(bitCnt + 9'h001);
  wire [3:0] stepFrame = bitWrap ? (frameWrap ? 4'h0 : 4'(frameCnt + 4'h1)) : frameCnt;
  wire [3:0] next_frameCnt = !lineFall ? frameCnt : restart ? (cfg.multiframe ? 4'h0 : frameCnt) : stepFrame;
  wire atBoundary = (bitCnt == 9'h000) && (!cfg.multiframe || frameCnt == 4'h0);
  wire sigFrame = (frameCnt == SIG_FRAME_A) || (frameCnt == SIG_FRAME_B);
  wire wideBit = (bitCnt == WIDE_BIT) && cfg.t1Mode && !cfg.multiframe && cfg.doubleWide && sigFrame;
  // output changes only on line edges, except esOutput where it follows bpFrame every cycle
  wire next_syncOut = esOutput ? bpFrame : lineFall ? (cfg.syncOutput & (atBoundary | wideBit)) : syncOut;
  wire sampleEdge = useSys ? sysFall : lineFall;

  // ======================================================================
  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      bitCnt       <= 9'h000;
      frameCnt     <= 4'h0;
      prevLineSync <= 1'b0;
      prevSysSync  <= 1'b0;
      syncOut      <= 1'b0;
      syncOe       <= 1'b0;
      serBit       <= 1'b0;
      serValid     <= 1'b0;
      lineBoundary <= 1'b0;
      sysBoundary  <= 1'b0;
    end else begin
      bitCnt       <= next_bitCnt;
      frameCnt     <= next_frameCnt;
      prevLineSync <= lineFall ? syncLevel : prevLineSync;
      // system sync sampled on system edge
      prevSysSync  <= sysFall ? syncLevel : prevSysSync;
      syncOut      <= next_syncOut;
      syncOe       <= cfg.syncOutput & ~(compat & cfg.esEnable);
      serBit       <= sampleEdge ? serLevel : serBit;
      serValid     <= sampleEdge;
      lineBoundary <= restart;
      sysBoundary  <= sysRise;
    end
  end

  // ======================================================================
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_ser_capture: assert property (sampleEdge |=> serValid && serBit == $past(serLevel))
    else $error("serial bit not captured on chosen edge");
  chk_sys_unused: assert property (!useSys && sysFall && !lineFall |=> !serValid)
    else $error("system clock used without elastic store");
  chk_sync_restart: assert property (restart |=> bitCnt == 9'h000)
    else $error("input sync did not restart frame");
  chk_narrow_pulse: assert property (syncOut && !esOutput && !cfg.doubleWide && $stable(cfg) |-> bitCnt == WIDE_BIT)
    else $error("frame pulse wider than one bit");
  chk_pulse_timing: assert property ($rose(syncOut) && !esOutput && $stable(esOutput) |-> $past(lineFall))
    else $error("sync output moved without line edge");
  chk_sys_boundary: assert property (sysRise |=> sysBoundary ##1 !sysBoundary)
    else $error("system sync boundary missed");
endmodule // tcss_port

// File: tcss_top.sv
// transmit clock and frame sync pin logic for eight ports, with register port and interrupt
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module tcss_top
  import tcss_pkg::*;
#(
  parameter int BP_FRAME_COUNT = BP_PER_FRAME
)(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // register port
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  output logic      [31:0]      regRdata,
  output logic                  irq,
  // transmit clock pins
  input  wire logic [NPORT-1:0] lineClk,
  input  wire logic [NPORT-1:0] rxClk,
  input  wire logic [NPORT-1:0] sysClk,
  input  wire logic             bpClk,
  // frame sync pins
  input  wire logic [NPORT-1:0] syncIn,
  output logic      [NPORT-1:0] syncOut,
  output logic      [NPORT-1:0] syncOe,
  input  wire logic             sharedSyncIn,
  output logic                  sharedSyncOut,
  output logic                  sharedSyncOe,
  // serial data pins and captured bits
  input  wire logic [NPORT-1:0] serData,
  output logic      [NPORT-1:0] serBit,
  output logic      [NPORT-1:0] serValid,
  // loss and freeze sources
  input  wire logic [NPORT-1:0] analogLoss,
  input  wire logic [NPORT-1:0] framerLoss,
  input  wire logic [NPORT-1:0] sigFreeze,
  // indicator outputs on system clock pins 2 to 8
  output logic      [NPORT-1:1] indOut,
  output logic      [NPORT-1:1] indOe
);
  // ======================================================================
  // declarations
  tcss_pins_type              pinStage1;
  tcss_pins_type              pinStage2;
  tcss_pins_type              pinStage3;
  tcss_pins_type              rawPins;
  logic [GBL_W-1:0]           globalCtrl;
  logic [2*NPORT-1:0]         indSelect;
  tcss_port_cfg_type          portCfg [NPORT];
  logic [STAT_W-1:0]          status;
  logic [STAT_W-1:0]          irqEnable;
  logic [15:0]                bpCnt;
  logic                       bpFrame;
  logic [NPORT-1:0]           lineBoundary;
  logic [NPORT-1:0]           sysBoundary;
  logic [NPORT-1:0]           portLineFall;
  logic [NPORT-1:0]           portSysFall;
  logic [NPORT-1:0]           portSyncLevel;
  logic [31:0]                portRead [NPORT];
  logic [NPORT-1:0]           portHit;

  // ======================================================================
  // pin synchronisers
  assign rawPins.lineClk    = lineClk;
  assign rawPins.rxClk      = rxClk;
  assign rawPins.sysClk     = sysClk;
  assign rawPins.syncIn     = syncIn;
  assign rawPins.serData    = serData;
  assign rawPins.bpClk      = bpClk;
  assign rawPins.sharedSync = sharedSyncIn;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pinStage1 <= '0;
      pinStage2 <= '0;
      pinStage3 <= '0;
    end else begin
      pinStage1 <= rawPins;
      pinStage2 <= pinStage1;
      pinStage3 <= pinStage2;
    end
  end

  // edge detection after the second stage
  wire [NPORT-1:0] txFall   = ~pinStage2.lineClk & pinStage3.lineClk;
  wire [NPORT-1:0] rxFall   = ~pinStage2.rxClk & pinStage3.rxClk;
  wire [NPORT-1:0] sysFall  = ~pinStage2.sysClk & pinStage3.sysClk;
  wire             bpRise   = pinStage2.bpClk & ~pinStage3.bpClk;

  // ======================================================================
  // global decode
  wire compat    = globalCtrl[GBL_COMPAT];
  // interleaved mode relies on synchronous clocks
  wire interleaved_bus_mode       = globalCtrl[GBL_IBO];
  wire sharedOut = globalCtrl[GBL_SHARED];
  wire wrGlobal  = regWrite && regAddr == ADDR_GLOBAL;
  wire wrIndSel  = regWrite && regAddr == ADDR_INDSEL;
  wire wrClear   = regWrite && regAddr == ADDR_CLEAR;
  wire wrEnable  = regWrite && regAddr == ADDR_ENABLE;
  wire [STAT_W-1:0] clearBits  = wrClear ? regWdata[STAT_W-1:0] : '0;
  wire [STAT_W-1:0] setBits    = {sysBoundary, lineBoundary};
  // set wins over a clear in the same cycle
  wire [STAT_W-1:0] next_status = (status & ~clearBits) | setBits;
  wire [STAT_W-1:0] next_irqEnable = wrEnable ? regWdata[STAT_W-1:0] : irqEnable;
  wire [15:0] bpLast = 16'(BP_FRAME_COUNT - 1);
  wire bpWrap = bpCnt == bpLast;
  // shared pin drives backplane frame pulse
  wire next_sharedOe = compat & sharedOut & portCfg[0].esEnable;

  // ======================================================================
  // per-port selection, configuration and engines
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      wire [7:0] cfgAddr = 8'(ADDR_PORT0 + ADDR_PORT_STEP * p);
      assign portHit[p] = regAddr == cfgAddr;
      assign portRead[p] = {{(32-CFG_W){1'b0}}, portCfg[p]};
      assign portLineFall[p] = portCfg[p].lineFromRx ? rxFall[p] : txFall[p];
      // in compat mode, port one system clock for all
      assign portSysFall[p] = compat ? sysFall[0] : sysFall[p];
      assign portSyncLevel[p] = (compat && portCfg[p].esEnable) ? pinStage2.sharedSync : pinStage2.syncIn[p];

      always_ff @(posedge mclk) begin
        if (rst) begin
          portCfg[p] <= '0;
        end else if (regWrite && portHit[p]) begin
          portCfg[p] <= tcss_port_cfg_type'(regWdata[CFG_W-1:0]);
        end
      end

      tcss_port u_port (
        .mclk         (mclk),
        .rst          (rst),
        .cfg          (portCfg[p]),
        .interleaved_bus_mode          (interleaved_bus_mode),
        .compat       (compat),
        .lineFall     (portLineFall[p]),
        .sysFall      (portSysFall[p]),
        .syncLevel    (portSyncLevel[p]),
        .serLevel     (pinStage2.serData[p]),
        .bpFrame      (bpFrame),
        .syncOut      (syncOut[p]),
        .syncOe       (syncOe[p]),
        .serBit       (serBit[p]),
        .serValid     (serValid[p]),
        .lineBoundary (lineBoundary[p]),
        .sysBoundary  (sysBoundary[p])
      );
    end
  endgenerate

  // ======================================================================
  // indicator pins 2 to 8
  generate
    for (p = 1; p < NPORT; p++) begin : g_ind
      wire [1:0] sel = indSelect[2*p+1:2*p];
      wire indValue = (sel == IND_ANALOG) ? analogLoss[p] :
                      (sel == IND_FRAMER) ? framerLoss[p] :
                      (sel == IND_FREEZE) ? sigFreeze[p] : 1'b0;
      always_ff @(posedge mclk) begin
        if (rst) begin
          indOut[p] <= 1'b0;
          indOe[p]  <= 1'b0;
        end else begin
          indOut[p] <= indValue & compat;
          // pins driven only in compat mode
          indOe[p]  <= compat;
        end
      end
    end
  endgenerate

  // ======================================================================
  // read decode
  wire anyPort = |portHit;
  logic [31:0] portValue;
  always_comb begin
    portValue = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (portHit[i]) begin
        portValue = portRead[i];
      end
    end
  end
  wire [31:0] readValue = (regAddr == ADDR_GLOBAL) ? {{(32-GBL_W){1'b0}}, globalCtrl} :
                          (regAddr == ADDR_INDSEL) ? {{(32-2*NPORT){1'b0}}, indSelect} :
                          (regAddr == ADDR_STATUS) ? {{(32-STAT_W){1'b0}}, status} :
                          (regAddr == ADDR_ENABLE) ? {{(32-STAT_W){1'b0}}, irqEnable} :
                          anyPort ? portValue : 32'h00000000;

  // ======================================================================
  // control registers, status and interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      globalCtrl <= '0;
      indSelect  <= '0;
      irqEnable  <= '0;
      status     <= '0;
      irq        <= 1'b0;
      regRdata   <= 32'h00000000;
    end else begin
      globalCtrl <= wrGlobal ? regWdata[GBL_W-1:0] : globalCtrl;
      indSelect  <= wrIndSel ? regWdata[2*NPORT-1:0] : indSelect;
      irqEnable  <= next_irqEnable;
      status     <= next_status;
      irq        <= |(next_status & next_irqEnable);
      regRdata   <= regRead ? readValue : 32'h00000000;
    end
  end

  // ======================================================================
  // backplane frame pulse generator
  always_ff @(posedge mclk) begin
    if (rst) begin
      bpCnt         <= 16'h0000;
      bpFrame       <= 1'b0;
      sharedSyncOut <= 1'b0;
      sharedSyncOe  <= 1'b0;
    end else begin
      if (bpRise) begin
        bpCnt   <= bpWrap ? 16'h0000 : 16'(bpCnt + 16'h0001);
        bpFrame <= bpWrap;
      end
      sharedSyncOut <= bpFrame & next_sharedOe;
      sharedSyncOe  <= next_sharedOe;
    end
  end

  // ======================================================================
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_master_clock: assert property (compat |-> portSysFall == {NPORT{sysFall[0]}})
    else $error("system clock not taken from port one");
  chk_indicator_off: assert property (!compat |=> indOe == '0 && indOut == '0)
    else $error("indicator driven outside compat mode");
  chk_analog_source: assert property (compat && indSelect[3:2] == IND_ANALOG |=> indOut[1] == $past(analogLoss[1]))
    else $error("analog loss not shown on indicator");
  chk_framer_source: assert property (compat && indSelect[5:4] == IND_FRAMER |=> indOut[2] == $past(framerLoss[2]))
    else $error("framer loss not shown on indicator");
  chk_bp_pulse: assert property (bpRise && bpWrap |=> bpFrame && bpCnt == 16'h0000)
    else $error("backplane frame pulse missing");
  chk_shared_sync: assert property (compat && portCfg[3].esEnable |-> portSyncLevel[3] == pinStage2.sharedSync)
    else $error("per-port system sync used in compat mode");
  chk_irq_level: assert property (|(status & irqEnable) |-> irq)
    else $error("interrupt low with enabled status set");
  chk_status_set: assert property (lineBoundary[0] |=> status[0] [*2])
    else $error("boundary event lost from status");
  chk_rx_clock: assert property (portCfg[4].lineFromRx |-> portLineFall[4] == rxFall[4])
    else $error("line clock not taken from receive clock");
endmodule // tcss_top

// File: tcss_backplane.sv
// far-side model: clocks, frame syncs and serial data for the transmit pins
`timescale 1ns/1ns
module tcss_backplane
  import tcss_pkg::*;
(
  // control
  input  wire logic [NPORT-1:0] sysMask,
  // pins
  output logic      [NPORT-1:0] lineClk,
  output logic      [NPORT-1:0] rxClk,
  output logic      [NPORT-1:0] sysClk,
  output logic                  bpClk,
  output logic      [NPORT-1:0] syncIn,
  output logic                  sharedSyncIn,
  output logic      [NPORT-1:0] serData
);
  logic lck = 1'b0;
  logic rck = 1'b0;
  logic sck = 1'b0;
  logic bck = 1'b0;
  // system clocks at half the line clock rate; interleaved mode unused
  initial forever begin
    #63 lck = 1'b1;
    #62 lck = 1'b0;
  end
  initial forever #100 rck = ~rck;
  initial forever #125 sck = ~sck;
  initial forever #80 bck = ~bck;
  initial syncIn = '0;
  initial sharedSyncIn = 1'b0;
  assign lineClk = {NPORT{lck}};
  assign rxClk   = {NPORT{rck}};
  assign sysClk  = {NPORT{sck}} & sysMask;
  assign bpClk   = bck;
  assign serData = 8'hA5;
  task pulse_line(input int p);
    @(posedge lineClk[p]);
    syncIn[p] = 1'b1;
    @(posedge lineClk[p]);
    syncIn[p] = 1'b0;
  endtask
  task pulse_sys(input int p);
    @(posedge sysClk[p]);
    syncIn[p] = 1'b1;
    @(posedge sysClk[p]);
    syncIn[p] = 1'b0;
  endtask
  task pulse_shared;
    @(posedge sysClk[0]);
    sharedSyncIn = 1'b1;
    @(posedge sysClk[0]);
    sharedSyncIn = 1'b0;
  endtask
endmodule // tcss_backplane

// File: transmit_clock_sync_select_tb.sv
// self-checking testbench of the transmit clock and frame sync pin block
`timescale 1ns/1ns
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module transmit_clock_sync_select_tb;
  import tcss_pkg::*;
  logic mclk, rst, regWrite, regRead, irq, bpClk, sharedSyncIn, sharedSyncOut, sharedSyncOe, mclr;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [NPORT-1:0] lineClk, rxClk, sysClk, syncIn, syncOut, syncOe, serData, serBit, serValid;
  logic [NPORT-1:0] analogLoss, framerLoss, sigFreeze, sysMask, prev, started, src;
  logic [NPORT-1:1] indOut, indOe;
  int fail_count, n_compared;
  int cnt[NPORT], per[NPORT], hw[NPORT], np[NPORT], nw[NPORT], nv[NPORT];
  tcss_top #(.BP_FRAME_COUNT(4)) DUT (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq), .lineClk(lineClk),
    .rxClk(rxClk), .sysClk(sysClk), .bpClk(bpClk), .syncIn(syncIn), .syncOut(syncOut), .syncOe(syncOe),
    .sharedSyncIn(sharedSyncIn), .sharedSyncOut(sharedSyncOut), .sharedSyncOe(sharedSyncOe),
    .serData(serData), .serBit(serBit), .serValid(serValid), .analogLoss(analogLoss),
    .framerLoss(framerLoss), .sigFreeze(sigFreeze), .indOut(indOut), .indOe(indOe));
  tcss_backplane far (.sysMask(sysMask), .lineClk(lineClk), .rxClk(rxClk), .sysClk(sysClk),
    .bpClk(bpClk), .syncIn(syncIn), .sharedSyncIn(sharedSyncIn), .serData(serData));
  // ====
  // clock, bus tasks and pulse monitor
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task wcfg(input int p, input logic [31:0] v);
    wr(8'(ADDR_PORT0 + ADDR_PORT_STEP * p), v);
  endtask
  function automatic logic inr(input int v, input int c, input int t);
    return (v >= c - t) && (v <= c + t);
  endfunction
  task tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    prev <= syncOut;
    for (int p = 0; p < NPORT; p++) begin
      cnt[p]++;
      hw[p]++;
      if (serValid[p] === 1'b1) nv[p]++;
      if (syncOut[p] === 1'b1 && prev[p] === 1'b0) begin
        per[p] = cnt[p];
        cnt[p] = 0;
        hw[p] = 0;
        started[p] = ~mclr;
      end
      if (syncOut[p] === 1'b0 && prev[p] === 1'b1 && started[p]) begin
        if (np[p] < 12 && hw[p] > 18) nw[p]++;
        np[p]++;
      end
      if (mclr) begin
        np[p] = 0;
        nw[p] = 0;
        nv[p] = 0;
        started[p] = 1'b0;
      end
    end
  end
  initial begin
    #900000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish;
  end
  // ====
  // tests
  initial begin
    rst = 1'b1;
    regAddr = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    analogLoss = 8'hAA;
    framerLoss = 8'h54;
    sigFreeze = 8'h38;
    sysMask = '1;
    mclr = 1'b1;
    prev = '0;
    started = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    foreach (cnt[p]) cnt[p] = 0;
    foreach (hw[p]) hw[p] = 0;
    `CHECK(syncOe, 8'h00)
    `CHECK(indOe, 7'h00)
    foreach (per[i]) begin
      rd(8'(4 * i + 4 * (i / 4) * 8), d);
      `CHECK(d, 32'h0)
    end
    rd(8'hFC, d);
    `CHECK(d, 32'h0)
    $display("test reset done");
    wr(ADDR_ENABLE, 32'h1);
    far.pulse_line(0);
    repeat (20) @(posedge mclk);
    rd(ADDR_STATUS, d);
    `CHECK(d, 32'h1)
    `CHECK(irq, 1'b1)
    wr(ADDR_CLEAR, 32'h1);
    repeat (2) @(posedge mclk);
    `CHECK(irq, 1'b0)
    wcfg(1, 32'h1);
    far.pulse_sys(1);
    repeat (20) @(posedge mclk);
    rd(ADDR_STATUS, d);
    `CHECK(d, 32'h200)
    `CHECK(syncOe[1], 1'b0)
    wr(ADDR_CLEAR, 32'hFFFF);
    $display("test sync inputs done");
    sysMask <= 8'h01;
    wr(ADDR_GLOBAL, 32'h1);
    wcfg(2, 32'h1);
    far.pulse_shared;
    repeat (20) @(posedge mclk);
    rd(ADDR_STATUS, d);
    `CHECK(d, 32'h600)
    `CHECK(sharedSyncOe, 1'b0)
    wr(ADDR_CLEAR, 32'hFFFF);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_INDSEL, {16{2'(c)}});
      repeat (3) @(posedge mclk);
      src = (c == 0) ? analogLoss : (c == 1) ? framerLoss : (c == 2) ? sigFreeze : 8'h00;
      `CHECK(indOut, src[7:1])
      `CHECK(indOe, 7'h7F)
    end
    wr(ADDR_GLOBAL, 32'h0);
    repeat (3) @(posedge mclk);
    `CHECK(indOe, 7'h00)
    `CHECK(indOut, 7'h00)
    $display("test compat mode done");
    sysMask <= '1;
    wcfg(3, 32'h1A);
    wcfg(4, 32'h16);
    wcfg(5, 32'h02);
    wcfg(6, 32'h03);
    wcfg(7, 32'h22);
    mclr <= 1'b0;
    repeat (62000) @(posedge mclk);
    `CHECK(syncOe, 8'hF8)
    `CHECK(inr(per[3], 2412, 2), 1'b1)
    `CHECK(nw[3], 2)
    `CHECK(inr(per[4], 28950, 2), 1'b1)
    `CHECK(inr(per[5], 3200, 2), 1'b1)
    `CHECK(inr(per[6], 64, 1), 1'b1)
    `CHECK(inr(per[7], 5120, 2), 1'b1)
    `CHECK(inr(nv[0], 4960, 1), 1'b1)
    `CHECK(inr(nv[1], 2480, 1), 1'b1)
    `CHECK(serBit, 8'hA5)
    $display("test sync outputs done");
    tally_and_finish;
  end
endmodule // transmit_clock_sync_select_tb
